//--- hdl/sop_array_top.sv
// Programmable AND-OR array with ten output macrocells, fuses held in flops.
// Assumes pins are asynchronous to CLK_IN and an APB3 master programs the array.
`timescale 1ns/1ps

// ****************************************************************
// Array top.
// ****************************************************************

module sop_array_top
  import sop_pkg::*;
(
  input wire logic CLK_IN,                  // System clock, 100 MHz.
  input wire logic RSTN_IN,                 // Asynchronous reset, active low.
  input wire logic GCLK_IN,                 // Global clock pin, also column 0.
  input wire logic [NUM_DED-2:0] DIN_IN,    // Dedicated input pins.
  input wire logic [NUM_MC-1:0] IO_IN,      // Level seen on the I/O pins.
  output logic [NUM_MC-1:0] IO_OUT,         // Level driven on the I/O pins.
  output logic [NUM_MC-1:0] IO_OE_OUT,      // I/O pin driver enables.
  input wire logic PSEL_IN,                 // APB select.
  input wire logic PENABLE_IN,              // APB enable.
  input wire logic PWRITE_IN,               // APB direction, high for write.
  input wire logic [ADDR_W-1:0] PADDR_IN,   // APB byte address.
  input wire logic [31:0] PWDATA_IN,        // APB write data.
  output logic [31:0] PRDATA_OUT,           // APB read data.
  output logic PREADY_OUT,                  // APB ready.
  output logic PSLVERR_OUT                  // APB error on unmapped address.
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************

  logic [NUM_DED+NUM_MC-1:0] pin_meta;
  logic [NUM_DED+NUM_MC-1:0] pin_sync;
  logic gclk_prev;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pin_meta <= '0;
      pin_sync <= '0;
      gclk_prev <= 1'b0;
    end else begin
      pin_meta <= {IO_IN, DIN_IN, GCLK_IN};
      pin_sync <= pin_meta;
      gclk_prev <= pin_sync[0];
    end
  end

  wire [NUM_DED-1:0] ded_sync = pin_sync[NUM_DED-1:0];
  wire [NUM_MC-1:0] io_sync = pin_sync[NUM_DED+NUM_MC-1:NUM_DED];
  // The global clock pin becomes a one-cycle enable on its rising edge.
  wire gclk_edge = pin_sync[0] & ~gclk_prev;

  // ****************************************************************
  // Fuse store and configuration.
  // ****************************************************************

  // A set fuse bit connects its column; an erased array has every column
  // connected, so every term is false and all pins stay undriven.
  logic [COL_W-1:0] fuse [NUM_TERMS];
  logic [31:0] config_reg;

  // ****************************************************************
  // APB decode.
  // ****************************************************************

  wire setup_phase = PSEL_IN & ~PENABLE_IN;
  wire access_done = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire [7:0] term_idx = PADDR_IN[10:TERM_IDX_LSB];
  wire term_word = PADDR_IN[TERM_WORD_BIT];
  wire aligned = PADDR_IN[1:0] == 2'b00;
  wire hit_term = aligned & ~PADDR_IN[11] & (term_idx < 8'(NUM_TERMS));
  wire hit_config = PADDR_IN == ADDR_CONFIG;
  wire hit_status = PADDR_IN == ADDR_STATUS;
  wire hit_pins = PADDR_IN == ADDR_PINS;
  wire mapped = hit_term | hit_config | hit_status | hit_pins;
  wire wr_term = access_done & PWRITE_IN & hit_term;
  wire wr_config = access_done & PWRITE_IN & hit_config;

  // ****************************************************************
  // Read data.
  // ****************************************************************

  logic [NUM_MC-1:0] mc_q;
  logic [NUM_MC-1:0] mc_pin;
  logic [NUM_MC-1:0] mc_oe;
  logic [NUM_MC-1:0] mc_fb;

  wire [7:0] safe_idx = hit_term ? term_idx : 8'h00;
  wire [63:0] fuse_ext = {{(64 - COL_W){1'b0}}, fuse[safe_idx]};
  wire [31:0] rd_term = term_word ? fuse_ext[63:32] : fuse_ext[31:0];
  wire [31:0] rd_status = (32'(mc_q) << STAT_Q_LSB) | (32'(mc_oe) << STAT_OE_LSB);
  wire [31:0] rd_pins = (32'(ded_sync) << PINS_DED_LSB) | (32'(io_sync) << PINS_IO_LSB);
  wire [31:0] rd_word = hit_term ? rd_term :
                        hit_config ? config_reg :
                        hit_status ? rd_status :
                        hit_pins ? rd_pins : 32'h0000_0000;

  // Zero wait states: ready rises in the first access cycle of every transfer.
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
    end else begin
      PREADY_OUT <= setup_phase;
      PSLVERR_OUT <= setup_phase & ~mapped;
      PRDATA_OUT <= (setup_phase & ~PWRITE_IN) ? rd_word : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Register writes.
  // ****************************************************************

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      config_reg <= CONFIG_RESET;
    end else if (wr_config) begin
      config_reg <= PWDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      for (int t = 0; t < NUM_TERMS; t++) begin
        fuse[t] <= FUSE_RESET;
      end
    end else if (wr_term) begin
      if (term_word) begin
        fuse[term_idx][COL_W-1:32] <= PWDATA_IN[COL_W-33:0];
      end else begin
        fuse[term_idx][31:0] <= PWDATA_IN;
      end
    end
  end

  wire [NUM_MC-1:0] mode_bits = config_reg[CFG_MODE_LSB +: NUM_MC];
  wire [NUM_MC-1:0] pol_bits = config_reg[CFG_POL_LSB +: NUM_MC];

  // ****************************************************************
  // AND array.
  // ****************************************************************

  // Columns: dedicated pins first, then one feedback line per macrocell,
  // all in true form first, then all again in complement form.
  wire [NUM_IN-1:0] col_true = {mc_fb, ded_sync};
  wire [COL_W-1:0] columns = {~col_true, col_true};
  logic [NUM_TERMS-1:0] term;

  genvar t;
  generate
    for (t = 0; t < NUM_TERMS; t++) begin : g_term
      assign term[t] = &(~fuse[t] | columns);
    end
  endgenerate

  wire areset_term = term[TERM_ARESET];
  wire preset_term = term[TERM_SPRESET];

  // ****************************************************************
  // Output macrocells.
  // ****************************************************************

  // Pin count trades freely: any combinatorial macrocell whose enable term is false frees
  // its pin as an array input through the feedback path.
  genvar k;
  generate
    for (k = 0; k < NUM_MC; k++) begin : g_mc
      localparam int NPT = pt_count(k);
      localparam int BASE = pt_base(k);
      sop_macrocell #(
        .NPT(NPT)
      ) u_mc (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .terms_in(term[BASE +: NPT]),
        .oe_term_in(term[TERM_OE_BASE + k]),
        .mode_in(mode_bits[k]),
        .pol_in(pol_bits[k]),
        .gclk_edge_in(gclk_edge),
        .preset_in(preset_term),
        .areset_in(areset_term),
        .pin_in(io_sync[k]),
        .pin_out(mc_pin[k]),
        .pin_oe_out(mc_oe[k]),
        .q_out(mc_q[k]),
        .fb_out(mc_fb[k])
      );
    end
  endgenerate

  // Pin outputs come straight from the macrocell flops.
  assign IO_OUT = mc_pin;
  assign IO_OE_OUT = mc_oe;

  // ****************************************************************
  // Checks.
  // ****************************************************************

  chk_powerup_clear: assert property (
    @(posedge CLK_IN) $rose(RSTN_IN) |-> (mc_q == '0) && (IO_OE_OUT == '0))
    else $error("registers not clear after power-up");
  chk_fuse_write: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (wr_term && !term_word) |=> fuse[$past(term_idx)][31:0] == $past(PWDATA_IN))
    else $error("fuse word not stored");
  chk_config_decode: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    wr_config |=> mode_bits == $past(PWDATA_IN[CFG_MODE_LSB +: NUM_MC]))
    else $error("mode bits not taken from config write");
  chk_global_edge: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    gclk_edge |=> !gclk_edge)
    else $error("clock edge enable longer than one cycle");
  chk_bus_ready: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    setup_phase |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("ready not a single access cycle");
  chk_unmapped_err: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (setup_phase && !mapped) |=> PSLVERR_OUT && PRDATA_OUT == 32'h0000_0000)
    else $error("unmapped access not flagged");
endmodule

//--- hdl/sop_macrocell.sv
// One output macrocell: OR of its product terms, register, polarity, enable.
// Assumes its product terms and the global clock edge arrive on CLK_IN's domain.
`timescale 1ns/1ps
module sop_macrocell #(
  parameter int NPT = 8
) (
  input wire logic clk_in,             // System clock.
  input wire logic rstn_in,            // Power-up reset, active low.
  input wire logic [NPT-1:0] terms_in, // Evaluated sum product terms.
  input wire logic oe_term_in,         // Dedicated output enable term.
  input wire logic mode_in,            // 0 registered, 1 combinatorial.
  input wire logic pol_in,             // 0 active low, 1 active high.
  input wire logic gclk_edge_in,       // Rising edge of the global clock pin.
  input wire logic preset_in,          // Shared synchronous preset term.
  input wire logic areset_in,          // Shared asynchronous reset term.
  input wire logic pin_in,             // Synchronised level on the pin.
  output logic pin_out,                // Level driven onto the pin.
  output logic pin_oe_out,             // Pin driver enable.
  output logic q_out,                  // Macrocell register.
  output logic fb_out                  // Feedback into the array.
);
  wire sum = |terms_in;
  wire next_pin = pol_in ? (mode_in ? sum : q_out) : ~(mode_in ? sum : q_out);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_out <= 1'b0;
    end else if (areset_in) begin
      q_out <= 1'b0;
    end else if (gclk_edge_in) begin
      q_out <= preset_in ? 1'b1 : sum;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_out <= 1'b0;
      pin_oe_out <= 1'b0;
    end else begin
      pin_out <= next_pin;
      pin_oe_out <= oe_term_in;
    end
  end

  // Combinatorial feedback uses the registered pin copy while the pin is enabled, which breaks the
  // loop through the array at the cost of one system cycle of lag.
  assign fb_out = !mode_in ? q_out : (pin_oe_out ? pin_out : pin_in);

  chk_reg_feedback: assert property (
    @(posedge clk_in) disable iff (!rstn_in) !mode_in |-> fb_out == q_out)
    else $error("registered feedback differs from register");
  chk_comb_feedback: assert property (
    @(posedge clk_in) disable iff (!rstn_in) (mode_in && !pin_oe_out) |-> fb_out == pin_in)
    else $error("disabled pin not fed back");
  chk_oe_follows: assert property (
    @(posedge clk_in) disable iff (!rstn_in) oe_term_in |=> pin_oe_out)
    else $error("enable term did not enable pin");
  chk_comb_output: assert property (
    @(posedge clk_in) disable iff (!rstn_in) mode_in |=> pin_out == ($past(pol_in) ~^ $past(sum)))
    else $error("combinatorial output wrong");
  chk_async_clear: assert property (
    @(posedge clk_in) disable iff (!rstn_in) areset_in |=> !q_out)
    else $error("reset term did not clear register");
  chk_sync_preset: assert property (
    @(posedge clk_in) disable iff (!rstn_in) (gclk_edge_in && preset_in && !areset_in) |=> q_out)
    else $error("preset term did not set register");
  chk_hold_no_edge: assert property (
    @(posedge clk_in) disable iff (!rstn_in) (!gclk_edge_in && !areset_in) |=> $stable(q_out))
    else $error("register changed without clock edge");
endmodule

//--- hdl/sop_pkg.sv
// Constants shared by the sum-of-products array top, its bench and the board model.
// Assumes a single 100 MHz system clock and an APB3 register port.
package sop_pkg;
  // ****************************************************************
  // Array shape.
  // ****************************************************************
  localparam int NUM_DED = 12;
  localparam int NUM_MC = 10;
  localparam int NUM_IN = 22;
  localparam int COL_W = 44;
  localparam int PT_BASE_COUNT = 8;
  localparam int PT_STEP = 2;
  localparam int NUM_PAIRS = 5;
  localparam int TERM_ARESET = 0;
  localparam int TERM_SPRESET = 1;
  localparam int TERM_OE_BASE = 2;
  localparam int TERM_SUM_BASE = 12;
  localparam int NUM_TERMS = 132;
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CONFIG = 12'h800;
  localparam logic [11:0] ADDR_STATUS = 12'h804;
  localparam logic [11:0] ADDR_PINS = 12'h808;
  localparam int TERM_IDX_LSB = 3;
  localparam int TERM_WORD_BIT = 2;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_POL_LSB = 16;
  localparam int STAT_Q_LSB = 0;
  localparam int STAT_OE_LSB = 16;
  localparam int PINS_DED_LSB = 0;
  localparam int PINS_IO_LSB = 16;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [43:0] FUSE_RESET = 44'hfff_ffff_ffff;

  // Product terms owned by macrocell k; pairs grow by two from eight.
  function automatic int pt_count(input int k);
    return PT_BASE_COUNT + PT_STEP * (k / 2);
  endfunction

  // First sum term index of macrocell k.
  function automatic int pt_base(input int k);
    int acc;
    acc = TERM_SUM_BASE;
    for (int j = 0; j < k; j++) begin
      acc = acc + pt_count(j);
    end
    return acc;
  endfunction
endpackage

//--- verification/sop_array_top_tb.sv
// Self-checking bench for the array top: APB programming, pins through a board model.
// Assumes the design answers APB in one access cycle and syncs pins with two flops.
`timescale 1ns/1ps
module sop_array_top_tb;
  import sop_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, gclk = 1'b0;
  logic [NUM_DED-2:0] din = '0;
  logic [NUM_MC-1:0] io_in, io_out, io_oe, drv_en = '0, drv_val = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err;
  int n_mismatch = 0, checks_done = 0;
  logic [6:0] rows [6];

  sop_array_top sop_array_top_inst (.CLK_IN(clk), .RSTN_IN(rstn), .GCLK_IN(gclk), .DIN_IN(din),
    .IO_IN(io_in), .IO_OUT(io_out), .IO_OE_OUT(io_oe), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
  sop_board_model sop_board_model_inst (.io_out_in(io_out), .io_oe_in(io_oe),
    .drv_en_in(drv_en), .drv_val_in(drv_val), .io_level_out(io_in));

  initial begin
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request is held until pready is sampled high; a hang falls to the watchdog.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_term(input int t, input logic [43:0] f);
    apb(1'b1, 12'(8 * t), f[31:0]);
    apb(1'b1, 12'(8 * t + 4), {20'h0, f[43:32]});
  endtask

  task automatic gclk_pulse();
    @(posedge clk);
    gclk <= 1'b1;
    repeat (4) @(posedge clk);
    gclk <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    logic dv, pv, ev, bv, e0, e1, eo;
    // Row: board-side din0, polarity of mc0, OE0 on, pin drive, out0, out1, oe0.
    rows = '{7'b0110001, 7'b1110111, 7'b1010001, 7'b0010111, 7'b1100000, 7'b1101010};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("oe after reset", 32'h0, {22'h0, io_oe});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status after reset", 32'h0, rd);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk("config after reset", CONFIG_RESET, rd);
    apb(1'b0, 12'h900, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, 12'h802, 32'h0);
    chk("misaligned err", 32'h1, {31'h0, err});
    // mc0 combinatorial from din0, mc1 combinatorial from feedback of mc0, mc2 toggles.
    set_term(12, 44'h000_0000_0002);
    set_term(20, 44'h000_0000_1000);
    set_term(28, 44'h010_0000_0000);
    set_term(3, 44'h0);
    set_term(4, 44'h0);
    for (int i = 0; i < 6; i++) begin
      {dv, pv, ev, bv, e0, e1, eo} = rows[i];
      din[0] <= dv;
      drv_val[0] <= bv;
      drv_en[0] <= ~ev;
      apb(1'b1, ADDR_CONFIG, {13'h0, 1'b1, 1'b1, pv, 14'h0, 2'b11});
      set_term(2, ev ? 44'h0 : FUSE_RESET);
      repeat (10) @(posedge clk);
      if (ev) begin
        chk("io_out0", {31'h0, e0}, {31'h0, io_out[0]});
      end
      chk("io_out1", {31'h0, e1}, {31'h0, io_out[1]});
      chk("io_oe0", {31'h0, eo}, {31'h0, io_oe[0]});
    end
    // Registered toggle in mc2 loads only on global clock rises.
    chk("q2 before clock", 32'h0, {31'h0, io_out[2]});
    // Pin 0 driven by the board, pins 1 and 2 by the array, the rest float high.
    apb(1'b0, ADDR_PINS, 32'h0);
    chk("pins dedicated", 32'h2, {20'h0, rd[11:0]});
    chk("pins io", 32'h3fb, {22'h0, rd[25:16]});
    gclk_pulse();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("q2 first rise", 32'h1, {31'h0, rd[2]});
    chk("pin2 first rise", 32'h1, {31'h0, io_out[2]});
    gclk_pulse();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("q2 second rise", 32'h0, {31'h0, rd[2]});
    set_term(1, 44'h0);
    repeat (10) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    // Registers of the combinatorial cells still load their sums: din0 and pin 0 are high.
    chk("preset waits clock", 32'h3, {22'h0, rd[9:0]});
    gclk_pulse();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("preset all", 32'h3ff, {22'h0, rd[9:0]});
    set_term(1, FUSE_RESET);
    set_term(0, 44'h0);
    repeat (6) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("async clear all", 32'h0, {22'h0, rd[9:0]});
    set_term(0, FUSE_RESET);
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    chk("ro write no err", 32'h0, {31'h0, err});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("ro write ignored", 32'h0, {22'h0, rd[9:0]});
    print_verdict();
  end
endmodule

//--- verification/sop_board_model.sv
// Board logic around the array pins: resolves each I/O wire and drives it on request.
// Assumes the bench changes the board drive levels just after a CLK_IN edge.
`timescale 1ns/1ps
module sop_board_model
  import sop_pkg::*;
(
  input wire logic [NUM_MC-1:0] io_out_in,   // Level the array drives.
  input wire logic [NUM_MC-1:0] io_oe_in,    // Array driver enables.
  input wire logic [NUM_MC-1:0] drv_en_in,   // Board driver enables.
  input wire logic [NUM_MC-1:0] drv_val_in,  // Board drive levels.
  output logic [NUM_MC-1:0] io_level_out     // Resolved wire level.
);
  // ****************************************************************
  // Wire resolution.
  // ****************************************************************
  // A wire nobody drives floats to the board pull-up, so no stale level lingers.
  always_comb begin
    for (int k = 0; k < NUM_MC; k++) begin
      if (io_oe_in[k]) begin
        io_level_out[k] = io_out_in[k];
      end else if (drv_en_in[k]) begin
        io_level_out[k] = drv_val_in[k];
      end else begin
        io_level_out[k] = 1'b1;
      end
    end
  end
endmodule
